// ### pmc_pkg.sv
// Purpose: Shared constants for the power mode control block.
// Assumes: Avalon-MM byte addresses, 32-bit data, word-aligned registers.
// Notes: Offsets are relative to the power unit base address.
package pmc_pkg;

	// Bus geometry
	localparam int PMC_ADDR_W = 4;
	localparam int PMC_DATA_W = 32;
	localparam int PMC_BE_W = 4;

	// Power unit placement on the peripheral bus
	localparam logic [31:0] PMC_BASE_ADDR = 32'h4000_7000;
	localparam logic [PMC_ADDR_W-1:0] PMC_CTL_OFFSET = 4'h0;
	localparam logic [PMC_ADDR_W-1:0] PMC_FLAGS_OFFSET = 4'h4;

	// Control register reset value and writable bits
	localparam logic [31:0] PMC_CTL_RESET = 32'h0000_8000;
	localparam logic [31:0] PMC_CTL_WMASK = 32'h0034_c1f3;
	localparam logic [31:0] PMC_CTL_LOCK_MASK = 32'h0000_00f0;

	// Control register field positions
	localparam int PMC_BIT_SRAM2_OFF = 21;
	localparam int PMC_BIT_SRAM1_OFF = 20;
	localparam int PMC_BIT_LOW_DRIVE = 18;
	localparam int PMC_BIT_OV_THRESH = 15;
	localparam int PMC_BIT_OV_ENABLE = 14;
	localparam int PMC_BIT_BACKUP_WEN = 8;
	localparam int PMC_LSB_UV_THRESH = 5;
	localparam int PMC_UV_THRESH_W = 3;
	localparam int PMC_BIT_UV_ENABLE = 4;
	localparam int PMC_BIT_STBY_CLEAR = 3;
	localparam int PMC_BIT_WAKE_CLEAR = 2;
	localparam int PMC_BIT_STBY_SEL = 1;
	localparam int PMC_BIT_REG_LP = 0;

	// Flags register field positions
	localparam int PMC_BIT_STBY_FLAG = 1;
	localparam int PMC_BIT_WAKE_FLAG = 0;
	localparam int PMC_NUM_FLAGS = 2;

	// Accepted byte-enable patterns
	localparam logic [PMC_BE_W-1:0] PMC_BE_LOW_HALF = 4'h3;
	localparam logic [PMC_BE_W-1:0] PMC_BE_HIGH_HALF = 4'hc;
	localparam logic [PMC_BE_W-1:0] PMC_BE_WORD = 4'hf;

	// Low-power sequencing states, Gray coded along run, deep-sleep, standby
	typedef enum logic [1:0] {
		PMC_ST_RUN = 2'b00,
		PMC_ST_DEEP = 2'b01,
		PMC_ST_STBY = 2'b11
	} pmc_state_t;

endpackage

// ### pmc_bus_port.sv
// Purpose: Avalon-MM wait handshake for the power mode control slave.
// Assumes: Master holds read or write until it sees waitrequest low.
// Notes: Two-cycle answer: sample edge, then commit edge.
module pmc_bus_port (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic read_i,
	input wire logic write_i,
	output logic waitrequest_o,
	output logic sample_o,
	output logic commit_o
);

	logic req;

	// Request seen while stalled, then released for one edge
	assign req = read_i | write_i;
	assign sample_o = req & waitrequest_o;
	assign commit_o = req & ~waitrequest_o;

	// Wait flop drops for one cycle per request
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			waitrequest_o <= 1'b1;
		end else if (sample_o) begin
			waitrequest_o <= 1'b0;
		end else begin
			waitrequest_o <= 1'b1;
		end
	end

endmodule

// ### pmc_sticky_flag.sv
// Purpose: One sticky status flag with set priority.
// Assumes: Set and clear come from logic on the same clock.
// Notes: A set in the clearing cycle keeps the flag high.
module pmc_sticky_flag (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic set_i,
	input wire logic clear_i,
	output logic flag_o
);

	// Set wins over clear
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			flag_o <= 1'b0;
		end else if (set_i) begin
			flag_o <= 1'b1;
		end else if (clear_i) begin
			flag_o <= 1'b0;
		end
	end

endmodule

// ### pmc_power_mode_ctrl.sv
// Purpose: Power mode control register, status flags and sleep choice.
// Assumes: reset_n_i is the power-on reset; other inputs share core_clk_i.
// Notes: Byte-only writes are answered but change nothing.
module pmc_power_mode_ctrl (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic sys_reset_i,
	input wire logic standby_wake_reset_i,
	input wire logic [pmc_pkg::PMC_ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [pmc_pkg::PMC_BE_W-1:0] avs_byteenable_i,
	input wire logic [pmc_pkg::PMC_DATA_W-1:0] avs_writedata_i,
	output logic [pmc_pkg::PMC_DATA_W-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic undervoltage_config_lock_i,
	input wire logic processor_deep_sleep_request_i,
	input wire logic internal_8mhz_oscillator_busy_i,
	input wire logic wakeup_event_i,
	output logic sram_bank2_off_o,
	output logic sram_bank1_off_o,
	output logic low_drive_enable_o,
	output logic overvoltage_threshold_sel_o,
	output logic overvoltage_detect_enable_o,
	output logic backup_write_enable_o,
	output logic [pmc_pkg::PMC_UV_THRESH_W-1:0] undervoltage_threshold_sel_o,
	output logic undervoltage_detect_enable_o,
	output logic standby_select_o,
	output logic standby_flag_clear_o,
	output logic wakeup_flag_clear_o,
	output logic standby_flag_o,
	output logic wakeup_flag_o,
	output logic deep_sleep_active_o,
	output logic standby_active_o,
	output logic regulator_low_power_o
);

	import pmc_pkg::*;

	// Bus decode, control word and flag nets
	logic bus_sample;
	logic bus_commit;
	logic hit_ctl;
	logic hit_flags;
	logic lanes_ok;
	logic ctl_write;
	logic [31:0] lane_mask;
	logic [31:0] write_mask;
	logic [31:0] power_mode_control_reg;
	logic [31:0] power_mode_control_next;
	logic [31:0] read_word;
	logic [PMC_NUM_FLAGS-1:0] flag_set;
	logic [PMC_NUM_FLAGS-1:0] flag_clear;
	logic [PMC_NUM_FLAGS-1:0] flag_value;
	logic ctl_reload;
	logic stby_clear_req;
	logic wake_clear_req;
	logic enter_deep;
	logic enter_stby;
	// Sleep sequencing state
	pmc_state_t state_reg;
	pmc_state_t state_next;

	// Bus wait handshake
	pmc_bus_port u_bus_port (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.read_i(avs_read_i),
		.write_i(avs_write_i),
		.waitrequest_o(avs_waitrequest_o),
		.sample_o(bus_sample),
		.commit_o(bus_commit)
	);

	assign hit_ctl = (avs_address_i[PMC_ADDR_W-1:2] == PMC_CTL_OFFSET[PMC_ADDR_W-1:2]);
	assign hit_flags = (avs_address_i[PMC_ADDR_W-1:2] == PMC_FLAGS_OFFSET[PMC_ADDR_W-1:2]);

	assign lanes_ok = (avs_byteenable_i == PMC_BE_LOW_HALF) ||
		(avs_byteenable_i == PMC_BE_HIGH_HALF) ||
		(avs_byteenable_i == PMC_BE_WORD);

	// Write to the control word takes effect at the commit edge
	assign ctl_write = bus_commit & avs_write_i & hit_ctl & lanes_ok;

	// Expand byte enables into a bit mask
	always_comb begin
		lane_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
			{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	end

	always_comb begin
		write_mask = lane_mask & PMC_CTL_WMASK;
		if (undervoltage_config_lock_i) begin
			write_mask = write_mask & ~PMC_CTL_LOCK_MASK;
		end
	end

	always_comb begin
		power_mode_control_next = (power_mode_control_reg & ~write_mask) |
			(avs_writedata_i & write_mask);
	end

	// reload on system reset or standby wakeup
	assign ctl_reload = sys_reset_i | standby_wake_reset_i;

	// Control register storage
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			power_mode_control_reg <= PMC_CTL_RESET;
		end else if (ctl_reload) begin
			power_mode_control_reg <= PMC_CTL_RESET;
		end else if (ctl_write) begin
			power_mode_control_reg <= power_mode_control_next;
		end
	end

	// standby clear request from low lane
	assign stby_clear_req = ctl_write & avs_byteenable_i[0] & avs_writedata_i[PMC_BIT_STBY_CLEAR];
	// wakeup clear request from low lane
	assign wake_clear_req = ctl_write & avs_byteenable_i[0] & avs_writedata_i[PMC_BIT_WAKE_CLEAR];

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			standby_flag_clear_o <= 1'b0;
			wakeup_flag_clear_o <= 1'b0;
		end else begin
			standby_flag_clear_o <= stby_clear_req;
			wakeup_flag_clear_o <= wake_clear_req;
		end
	end

	// Flag set sources
	always_comb begin
		flag_set = '0;
		flag_set[PMC_BIT_STBY_FLAG] = (state_reg != PMC_ST_STBY) && (state_next == PMC_ST_STBY);
		flag_set[PMC_BIT_WAKE_FLAG] = wakeup_event_i;
	end

	// standby flag cleared by its pulse only
	// wakeup flag also cleared by system reset
	always_comb begin
		flag_clear = '0;
		flag_clear[PMC_BIT_STBY_FLAG] = standby_flag_clear_o;
		flag_clear[PMC_BIT_WAKE_FLAG] = wakeup_flag_clear_o | sys_reset_i;
	end

	// One sticky cell per status flag
	genvar gi;
	generate
		for (gi = 0; gi < PMC_NUM_FLAGS; gi++) begin : g_flag
			pmc_sticky_flag u_flag (
				.core_clk_i(core_clk_i),
				.reset_n_i(reset_n_i),
				.set_i(flag_set[gi]),
				.clear_i(flag_clear[gi]),
				.flag_o(flag_value[gi])
			);
		end
	endgenerate

	// Flag outputs come straight from the sticky cells
	assign standby_flag_o = flag_value[PMC_BIT_STBY_FLAG];
	assign wakeup_flag_o = flag_value[PMC_BIT_WAKE_FLAG];

	assign enter_deep = processor_deep_sleep_request_i & ~power_mode_control_reg[PMC_BIT_STBY_SEL];
	assign enter_stby = processor_deep_sleep_request_i & power_mode_control_reg[PMC_BIT_STBY_SEL];

	// Sleep sequencing next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			PMC_ST_RUN: begin
				if (enter_stby) begin
					state_next = PMC_ST_STBY;
				end else if (enter_deep) begin
					state_next = PMC_ST_DEEP;
				end
			end
			PMC_ST_DEEP: begin
				if (!processor_deep_sleep_request_i) begin
					state_next = PMC_ST_RUN;
				end
			end
			PMC_ST_STBY: begin
				if (standby_wake_reset_i) begin
					state_next = PMC_ST_RUN;
				end
			end
			default: begin
				state_next = PMC_ST_RUN;
			end
		endcase
		if (sys_reset_i) begin
			state_next = PMC_ST_RUN;
		end
	end

	// Sleep state register
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= PMC_ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// Mode indications
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			deep_sleep_active_o <= 1'b0;
			standby_active_o <= 1'b0;
		end else begin
			deep_sleep_active_o <= (state_next == PMC_ST_DEEP);
			standby_active_o <= (state_next == PMC_ST_STBY);
		end
	end

	// Deep-sleep options act only in deep-sleep
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sram_bank2_off_o <= 1'b0;
			sram_bank1_off_o <= 1'b0;
			low_drive_enable_o <= 1'b0;
			regulator_low_power_o <= 1'b0;
		end else begin
			sram_bank2_off_o <= (state_next == PMC_ST_DEEP) && power_mode_control_next_q(PMC_BIT_SRAM2_OFF);
			sram_bank1_off_o <= (state_next == PMC_ST_DEEP) && power_mode_control_next_q(PMC_BIT_SRAM1_OFF);
			low_drive_enable_o <= (state_next == PMC_ST_DEEP) && power_mode_control_next_q(PMC_BIT_LOW_DRIVE);
			regulator_low_power_o <= (state_next == PMC_ST_DEEP) &&
				power_mode_control_next_q(PMC_BIT_REG_LP) && !internal_8mhz_oscillator_busy_i;
		end
	end

	// Value the control word holds after this edge
	function automatic logic power_mode_control_next_q(input int bit_idx);
		logic [31:0] word;
		word = power_mode_control_reg;
		if (ctl_reload) begin
			word = PMC_CTL_RESET;
		end else if (ctl_write) begin
			word = power_mode_control_next;
		end
		return word[bit_idx];
	endfunction

	// Detector, backup and mode settings follow the register
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			overvoltage_threshold_sel_o <= PMC_CTL_RESET[PMC_BIT_OV_THRESH];
			overvoltage_detect_enable_o <= PMC_CTL_RESET[PMC_BIT_OV_ENABLE];
			backup_write_enable_o <= PMC_CTL_RESET[PMC_BIT_BACKUP_WEN];
			undervoltage_threshold_sel_o <= PMC_CTL_RESET[PMC_LSB_UV_THRESH +: PMC_UV_THRESH_W];
			undervoltage_detect_enable_o <= PMC_CTL_RESET[PMC_BIT_UV_ENABLE];
			standby_select_o <= PMC_CTL_RESET[PMC_BIT_STBY_SEL];
		end else begin
			overvoltage_threshold_sel_o <= power_mode_control_next_q(PMC_BIT_OV_THRESH);
			overvoltage_detect_enable_o <= power_mode_control_next_q(PMC_BIT_OV_ENABLE);
			backup_write_enable_o <= power_mode_control_next_q(PMC_BIT_BACKUP_WEN);
			undervoltage_threshold_sel_o <= {power_mode_control_next_q(PMC_LSB_UV_THRESH + 2),
				power_mode_control_next_q(PMC_LSB_UV_THRESH + 1),
				power_mode_control_next_q(PMC_LSB_UV_THRESH)};
			undervoltage_detect_enable_o <= power_mode_control_next_q(PMC_BIT_UV_ENABLE);
			standby_select_o <= power_mode_control_next_q(PMC_BIT_STBY_SEL);
		end
	end

	// Read mux, clear bits always zero
	always_comb begin
		read_word = '0;
		if (hit_ctl) begin
			read_word = power_mode_control_reg;
			read_word[PMC_BIT_STBY_CLEAR] = 1'b0;
			read_word[PMC_BIT_WAKE_CLEAR] = 1'b0;
		end else if (hit_flags) begin
			read_word[PMC_BIT_STBY_FLAG] = flag_value[PMC_BIT_STBY_FLAG];
			read_word[PMC_BIT_WAKE_FLAG] = flag_value[PMC_BIT_WAKE_FLAG];
		end
	end

	// Read data captured at the sample edge, held through commit
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			avs_readdata_o <= '0;
		end else if (bus_sample && avs_read_i) begin
			avs_readdata_o <= read_word;
		end
	end

endmodule

// ### pmc_power_mode_ctrl_assertions.sv
// Purpose: Port-level checker for the power mode control block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Bound to every instance of the top module.
module pmc_power_mode_ctrl_chk (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic sys_reset_i,
	input wire logic standby_wake_reset_i,
	input wire logic [pmc_pkg::PMC_ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [pmc_pkg::PMC_BE_W-1:0] avs_byteenable_i,
	input wire logic [pmc_pkg::PMC_DATA_W-1:0] avs_writedata_i,
	input wire logic [pmc_pkg::PMC_DATA_W-1:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic undervoltage_config_lock_i,
	input wire logic wakeup_event_i,
	input wire logic overvoltage_threshold_sel_o,
	input wire logic backup_write_enable_o,
	input wire logic [pmc_pkg::PMC_UV_THRESH_W-1:0] undervoltage_threshold_sel_o,
	input wire logic undervoltage_detect_enable_o,
	input wire logic standby_select_o,
	input wire logic standby_flag_clear_o,
	input wire logic wakeup_flag_clear_o,
	input wire logic standby_flag_o,
	input wire logic wakeup_flag_o
);
	import pmc_pkg::*;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	// Completed control write touching lane 0
	wire logic done = avs_write_i && !avs_waitrequest_o && avs_address_i[3:2] == 2'b00;
	wire logic lane0 = avs_byteenable_i == PMC_BE_WORD || avs_byteenable_i == PMC_BE_LOW_HALF;
	wire logic quiet = !sys_reset_i && !standby_wake_reset_i;

	a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("request not answered next cycle");
	a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low too long");
	a_stby_pulse: assert property (standby_flag_clear_o == $past(done && lane0 && avs_writedata_i[3]))
		else $error("standby clear pulse wrong");
	a_wake_pulse: assert property (wakeup_flag_clear_o == $past(done && lane0 && avs_writedata_i[2]))
		else $error("wakeup clear pulse wrong");
	a_read_zero: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i[3:2] == 2'b00
		|-> (avs_readdata_o & ~PMC_CTL_WMASK) == 32'h0)
		else $error("unstored bits read nonzero");
	a_reset_reload: assert property (sys_reset_i || standby_wake_reset_i |=> overvoltage_threshold_sel_o
		&& !backup_write_enable_o && !standby_select_o && !undervoltage_detect_enable_o)
		else $error("control not reloaded");
	a_wake_sysrst: assert property (sys_reset_i && !wakeup_event_i |=> !wakeup_flag_o)
		else $error("wakeup flag survived system reset");
	a_stby_hold: assert property ($fell(standby_flag_o) |-> standby_flag_clear_o || $past(standby_flag_clear_o))
		else $error("standby flag fell without clear");
	a_lock_hold: assert property (undervoltage_config_lock_i && quiet
		|=> $stable({undervoltage_threshold_sel_o, undervoltage_detect_enable_o}))
		else $error("locked detector bits changed");
	a_copy_write: assert property (done && lane0 && quiet
		|=> {backup_write_enable_o, standby_select_o} == $past({avs_writedata_i[8], avs_writedata_i[1]}))
		else $error("written control bits not copied");
endmodule

bind pmc_power_mode_ctrl pmc_power_mode_ctrl_chk u_chk (.*);

// ### tb_pmc_power_mode_ctrl.sv
// Purpose: Self-checking bench for the power mode control block.
// Assumes: Avalon slave answers through waitrequest.
// Notes: Random data from a fixed-seed shift register.
module tb_pmc_power_mode_ctrl;
	timeunit 1ns;
	timeprecision 100ps;
	import pmc_pkg::*;
	logic core_clk_i = 1'b0, reset_n_i = 1'b0, sys_reset_i = 1'b0, standby_wake_reset_i = 1'b0;
	logic avs_read_i = 1'b0, avs_write_i = 1'b0, undervoltage_config_lock_i = 1'b0, wakeup_event_i = 1'b0;
	logic processor_deep_sleep_request_i = 1'b0, internal_8mhz_oscillator_busy_i = 1'b0;
	logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hf;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rng, q, d;
	logic avs_waitrequest_o, sram_bank2_off_o, sram_bank1_off_o, low_drive_enable_o, overvoltage_threshold_sel_o;
	logic overvoltage_detect_enable_o, backup_write_enable_o, undervoltage_detect_enable_o, standby_select_o;
	logic standby_flag_clear_o, wakeup_flag_clear_o, standby_flag_o, wakeup_flag_o, deep_sleep_active_o;
	logic standby_active_o, regulator_low_power_o;
	logic [2:0] undervoltage_threshold_sel_o;
	int failures = 0, samples_checked = 0;
	// Observed copies and deep-sleep group
	wire logic [31:0] obs = {24'h0, overvoltage_threshold_sel_o, overvoltage_detect_enable_o,
		backup_write_enable_o, undervoltage_threshold_sel_o, undervoltage_detect_enable_o, standby_select_o};
	wire logic [31:0] dsl = {27'h0, deep_sleep_active_o, sram_bank2_off_o, sram_bank1_off_o,
		low_drive_enable_o, regulator_low_power_o};

	pmc_power_mode_ctrl dut (.*);

	always #2.5 core_clk_i = ~core_clk_i;

	// Expected copies of a control word
	function automatic logic [31:0] cp(input logic [31:0] v);
		return {24'h0, v[15], v[14], v[8], v[7:5], v[4], v[1]};
	endfunction

	// Shift register for random data
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic conclude;
		$display("checks=%0d failures=%0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// One bus transfer, held until waitrequest low
	task automatic acc(input logic w, input logic [3:0] a, input logic [3:0] b, input logic [31:0] v,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge core_clk_i);
		avs_read_i <= !w;
		avs_write_i <= w;
		avs_address_i <= a;
		avs_byteenable_i <= b;
		avs_writedata_i <= v;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 20);
		r = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		if (n >= 20) begin
			failures++;
			conclude();
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask

	initial begin
		rng = 32'h0001_3d7f;
		cyc(4);
		reset_n_i <= 1'b1;
		// Reset value, mapping and an unmapped place
		acc(1'b0, 4'h0, 4'hf, 32'h0, q);
		chk(q, PMC_CTL_RESET);
		chk(obs, cp(PMC_CTL_RESET));
		acc(1'b0, 4'h8, 4'hf, 32'h0, q);
		chk(q, 32'h0);
		// Random words, every threshold code
		for (int i = 0; i < 8; i++) begin
			rng = nxt(rng);
			d = (rng & PMC_CTL_WMASK & ~32'he0) | 32'(i << 5);
			acc(1'b1, 4'h0, 4'hf, d, q);
			acc(1'b0, 4'h0, 4'hf, 32'h0, q);
			chk(q, d);
			chk(obs, cp(d));
		end
		// Half-word lanes
		acc(1'b1, 4'h0, PMC_BE_WORD, 32'h0, q);
		acc(1'b1, 4'h0, PMC_BE_HIGH_HALF, 32'h0034_c1f3, q);
		acc(1'b0, 4'h0, 4'hf, 32'h0, q);
		chk(q, 32'h0034_0000);
		acc(1'b1, 4'h0, PMC_BE_LOW_HALF, 32'h0000_c1f3, q);
		acc(1'b0, 4'h0, 4'hf, 32'h0, q);
		chk(q, 32'h0034_c1f3);
		// Byte-only write is answered and ignored
		acc(1'b1, 4'h0, 4'h1, 32'h0, q);
		acc(1'b0, 4'h0, 4'hf, 32'h0, q);
		chk(q, 32'h0034_c1f3);
		// Locked detector bits
		undervoltage_config_lock_i <= 1'b1;
		acc(1'b1, 4'h0, 4'hf, 32'h0000_c002, q);
		acc(1'b0, 4'h0, 4'hf, 32'h0, q);
		chk(q, 32'h0000_c0f2);
		undervoltage_config_lock_i <= 1'b0;
		// Wakeup flag set and cleared
		wakeup_event_i <= 1'b1;
		cyc(1);
		wakeup_event_i <= 1'b0;
		acc(1'b0, 4'h4, 4'hf, 32'h0, q);
		chk(q, 32'h1);
		acc(1'b1, 4'h0, 4'hf, 32'h0000_0006, q);
		acc(1'b0, 4'h0, 4'hf, 32'h0, q);
		chk(q, 32'h2);
		acc(1'b0, 4'h4, 4'hf, 32'h0, q);
		chk(q, 32'h0);
		// Standby entry and wakeup reload
		processor_deep_sleep_request_i <= 1'b1;
		cyc(1);
		processor_deep_sleep_request_i <= 1'b0;
		cyc(1);
		chk({28'h0, deep_sleep_active_o, wakeup_flag_o, standby_active_o, standby_flag_o}, 32'h3);
		standby_wake_reset_i <= 1'b1;
		cyc(1);
		standby_wake_reset_i <= 1'b0;
		acc(1'b0, 4'h0, 4'hf, 32'h0, q);
		chk(q, PMC_CTL_RESET);
		// System reset keeps standby flag, drops wakeup flag
		wakeup_event_i <= 1'b1;
		cyc(1);
		wakeup_event_i <= 1'b0;
		sys_reset_i <= 1'b1;
		cyc(1);
		sys_reset_i <= 1'b0;
		acc(1'b0, 4'h4, 4'hf, 32'h0, q);
		chk(q, 32'h2);
		acc(1'b1, 4'h0, 4'hf, 32'h0000_8008, q);
		acc(1'b0, 4'h4, 4'hf, 32'h0, q);
		chk(q, 32'h0);
		// Deep-sleep options and oscillator override
		acc(1'b1, 4'h0, 4'hf, 32'h0034_0001, q);
		processor_deep_sleep_request_i <= 1'b1;
		cyc(3);
		chk(dsl, 32'h1f);
		internal_8mhz_oscillator_busy_i <= 1'b1;
		cyc(3);
		chk(dsl, 32'h1e);
		internal_8mhz_oscillator_busy_i <= 1'b0;
		cyc(3);
		chk(dsl, 32'h1f);
		processor_deep_sleep_request_i <= 1'b0;
		cyc(3);
		chk(dsl, 32'h0);
		conclude();
	end
endmodule
